//--- design/servo_cmd_params.svh
`ifndef SERVO_CMD_PARAMS_SVH
`define SERVO_CMD_PARAMS_SVH

// Register byte offsets on the APB port.
`define OFS_CONTROL_MODE      12'h000
`define OFS_ENABLE_POLARITY   12'h004
`define OFS_DIRECTION         12'h008
`define OFS_PRESET_BASE       12'h020
`define OFS_STATUS            12'h040
`define OFS_POSITION          12'h044
`define OFS_INT_TARGET        12'h048

// Reset values.
`define RST_CONTROL_MODE      4'h0
`define RST_ENABLE_POLARITY   1'h0
`define RST_DIRECTION         1'h0
`define RST_PRESET_SPEED      16'h0000

// Field layout and sizes.
`define PRESET_COUNT          8
`define CMD_WIDTH             16
`define POS_WIDTH             32
`define MODE_WIDTH            4

`endif

//--- design/servo_cmd_pkg.sv
package servo_cmd_pkg;

	// Basic command sources that the drive can regulate from.
	typedef enum logic [2:0]
	{
		SRC_PULSE_POSITION,
		SRC_ANALOG_SPEED,
		SRC_ANALOG_TORQUE,
		SRC_PRESET_SPEED,
		SRC_INTERNAL_POSITION
	} source_type;

	// Servo-on state machine.
	typedef enum logic [0:0]
	{
		ST_SERVO_OFF,
		ST_SERVO_ON
	} servo_state_type;

endpackage

//--- design/servo_mode_and_enable_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "servo_cmd_params.svh"

module servo_mode_and_enable_control
	import servo_cmd_pkg::*;
(
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_psel,
	input  wire logic                   i_penable,
	input  wire logic                   i_pwrite,
	input  wire logic [11:0]            i_paddr,
	input  wire logic [31:0]            i_pwdata,
	output logic      [31:0]            o_prdata,
	output logic                        o_pready,
	output logic                        o_pslverr,
	input  wire logic                   i_servo_on,
	input  wire logic                   i_cmd_pulse,
	input  wire logic                   i_cmd_sign,
	input  wire logic [15:0]            i_speed_cmd,
	input  wire logic [15:0]            i_torque_cmd,
	input  wire logic                   i_preset_speed_select_0,
	input  wire logic                   i_preset_speed_select_1,
	input  wire logic                   i_preset_speed_select_2,
	input  wire logic                   i_mode_switch,
	input  wire logic                   i_enc_a,
	input  wire logic                   i_enc_b,
	output logic                        o_drive_enable,
	output logic                        o_brake_interlock_output,
	output logic      [2:0]             o_active_source,
	output logic      [31:0]            o_position_target,
	output logic      [15:0]            o_speed_ref,
	output logic      [15:0]            o_torque_ref,
	output logic                        o_enc_out_a,
	output logic                        o_enc_out_b
);

	// =====================================================================
	// Register bus
	// =====================================================================
	logic [3:0]  control_mode_setting_ff;
	logic [3:0]  nxt_control_mode_setting;
	logic        enable_polarity_setting_ff;
	logic        nxt_enable_polarity_setting;
	logic        reverse_ff;
	logic        nxt_reverse;
	logic [15:0] preset_ff [`PRESET_COUNT];
	logic [15:0] nxt_preset [`PRESET_COUNT];
	logic [31:0] int_target_ff;
	logic [31:0] nxt_int_target;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic        err_ff;
	logic        nxt_err;
	logic        wr_access;
	logic        rd_access;
	logic        hit;

	// Slave answers in the first access cycle, so pready is a plain decode of the access phase.
	assign o_pready  = i_psel & i_penable;
	assign wr_access = i_psel & i_penable & i_pwrite;
	assign rd_access = i_psel & ~i_penable & ~i_pwrite;

	// Write decode in the access phase and read-data capture during setup so the data is a flop in the access phase.
	always_comb
	begin
		nxt_control_mode_setting    = control_mode_setting_ff;
		nxt_enable_polarity_setting = enable_polarity_setting_ff;
		nxt_reverse                 = reverse_ff;
		nxt_int_target              = int_target_ff;
		nxt_preset                  = preset_ff;
		nxt_rdata                   = rdata_ff;
		nxt_err                     = 1'b0;
		hit                         = 1'b1;
		case (i_paddr)
			`OFS_CONTROL_MODE:    nxt_rdata = {28'h0000000, control_mode_setting_ff};
			`OFS_ENABLE_POLARITY: nxt_rdata = {31'h0, enable_polarity_setting_ff};
			`OFS_DIRECTION:       nxt_rdata = {31'h0, reverse_ff};
			`OFS_STATUS:          nxt_rdata = {25'h0, o_active_source, 2'h0,
								o_brake_interlock_output, o_drive_enable};
			`OFS_POSITION:        nxt_rdata = o_position_target;
			`OFS_INT_TARGET:      nxt_rdata = int_target_ff;
			default:
			begin
				if ((i_paddr >= `OFS_PRESET_BASE) && (i_paddr < `OFS_PRESET_BASE + 12'h020)
					&& (i_paddr[1:0] == 2'h0))
					nxt_rdata = {16'h0000, preset_ff[i_paddr[4:2]]};
				else
				begin
					nxt_rdata = 32'h00000000;
					hit       = 1'b0;
				end
			end
		endcase
		if (!rd_access)
			nxt_rdata = rdata_ff;
		if (i_psel & ~i_penable)
			nxt_err = ~hit;
		else
			nxt_err = err_ff;
		if (wr_access & hit)
		begin
			case (i_paddr)
				`OFS_CONTROL_MODE:    nxt_control_mode_setting    = i_pwdata[3:0];
				`OFS_ENABLE_POLARITY: nxt_enable_polarity_setting = i_pwdata[0];
				`OFS_DIRECTION:       nxt_reverse                 = i_pwdata[0];
				`OFS_INT_TARGET:      nxt_int_target              = i_pwdata;
				`OFS_STATUS, `OFS_POSITION: ;
				default:              nxt_preset[i_paddr[4:2]]    = i_pwdata[15:0];
			endcase
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			control_mode_setting_ff    <= `RST_CONTROL_MODE;
			enable_polarity_setting_ff <= `RST_ENABLE_POLARITY;
			reverse_ff                 <= `RST_DIRECTION;
			int_target_ff              <= 32'h00000000;
			preset_ff                  <= '{default: `RST_PRESET_SPEED};
			rdata_ff                   <= 32'h00000000;
			err_ff                     <= 1'b0;
		end
		else
		begin
			control_mode_setting_ff    <= nxt_control_mode_setting;
			enable_polarity_setting_ff <= nxt_enable_polarity_setting;
			reverse_ff                 <= nxt_reverse;
			int_target_ff              <= nxt_int_target;
			preset_ff                  <= nxt_preset;
			rdata_ff                   <= nxt_rdata;
			err_ff                     <= nxt_err;
		end
	end

	assign o_prdata  = rdata_ff;
	assign o_pslverr = o_pready & err_ff;

	// =====================================================================
	// Servo-on and mode selection
	// =====================================================================
	servo_state_type state_ff;
	servo_state_type nxt_state;
	logic            servo_on_active;
	source_type      source;

	// Polarity 0 reads a low input as on.
	assign servo_on_active = enable_polarity_setting_ff ? i_servo_on : ~i_servo_on;

	always_comb
	begin
		nxt_state = servo_on_active ? ST_SERVO_ON : ST_SERVO_OFF;
	end

	// Paired modes: the switch input picks the second mode of each pair.
	always_comb
	begin
		case (control_mode_setting_ff)
			4'h0:    source = SRC_PULSE_POSITION;
			4'h1:    source = SRC_ANALOG_SPEED;
			4'h2:    source = SRC_ANALOG_TORQUE;
			4'h3:    source = SRC_PRESET_SPEED;
			4'h4:    source = i_mode_switch ? SRC_ANALOG_SPEED : SRC_PRESET_SPEED;
			4'h5:    source = i_mode_switch ? SRC_PULSE_POSITION : SRC_PRESET_SPEED;
			4'h6:    source = i_mode_switch ? SRC_ANALOG_TORQUE : SRC_PRESET_SPEED;
			4'h7:    source = i_mode_switch ? SRC_ANALOG_SPEED : SRC_PULSE_POSITION;
			4'h8:    source = i_mode_switch ? SRC_ANALOG_TORQUE : SRC_PULSE_POSITION;
			4'h9:    source = i_mode_switch ? SRC_ANALOG_TORQUE : SRC_ANALOG_SPEED;
			4'hA:    source = SRC_INTERNAL_POSITION;
			default: source = SRC_PULSE_POSITION;
		endcase
	end

	// =====================================================================
	// Command path
	// =====================================================================
	logic        pulse_d_ff;
	logic        nxt_pulse_d;
	logic [31:0] pos_ff;
	logic [31:0] nxt_pos;
	logic [15:0] spd_ff;
	logic [15:0] nxt_spd;
	logic [15:0] trq_ff;
	logic [15:0] nxt_trq;
	logic [2:0]  src_ff;
	logic        enc_a_ff;
	logic        enc_b_ff;
	logic        pulse_edge;
	logic        fwd;
	logic [2:0]  preset_idx;

	assign pulse_edge = i_cmd_pulse & ~pulse_d_ff;
	// Reverse mode flips only the commanded direction, never any output polarity.
	assign fwd        = i_cmd_sign ^ reverse_ff;
	assign preset_idx = {i_preset_speed_select_2, i_preset_speed_select_1, i_preset_speed_select_0};

	// Each pulse edge moves the target one count; its rate therefore sets the speed.
	always_comb
	begin
		nxt_pulse_d = i_cmd_pulse;
		nxt_pos     = pos_ff;
		nxt_spd     = 16'h0000;
		nxt_trq     = 16'h0000;
		if (nxt_state == ST_SERVO_ON)
		begin
			case (source)
				SRC_PULSE_POSITION:
				begin
					if (pulse_edge)
						nxt_pos = fwd ? pos_ff + 32'h00000001 : pos_ff - 32'h00000001;
				end
				SRC_ANALOG_SPEED:   nxt_spd = reverse_ff ? 16'h0000 - i_speed_cmd : i_speed_cmd;
				SRC_ANALOG_TORQUE:  nxt_trq = reverse_ff ? 16'h0000 - i_torque_cmd : i_torque_cmd;
				SRC_PRESET_SPEED:   nxt_spd = reverse_ff ? 16'h0000 - preset_ff[preset_idx]
									: preset_ff[preset_idx];
				SRC_INTERNAL_POSITION: nxt_pos = int_target_ff;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			state_ff   <= ST_SERVO_OFF;
			pulse_d_ff <= 1'b0;
			pos_ff     <= 32'h00000000;
			spd_ff     <= 16'h0000;
			trq_ff     <= 16'h0000;
			src_ff     <= 3'h0;
			enc_a_ff   <= 1'b0;
			enc_b_ff   <= 1'b0;
		end
		else
		begin
			state_ff   <= nxt_state;
			pulse_d_ff <= nxt_pulse_d;
			pos_ff     <= nxt_pos;
			spd_ff     <= nxt_spd;
			trq_ff     <= nxt_trq;
			src_ff     <= source;
			enc_a_ff   <= i_enc_a;
			enc_b_ff   <= i_enc_b;
		end
	end

	assign o_drive_enable           = (state_ff == ST_SERVO_ON);
	// Brake releases only while the drive is energised, so the host can follow it.
	assign o_brake_interlock_output = (state_ff == ST_SERVO_ON);
	assign o_active_source          = src_ff;
	assign o_position_target        = pos_ff;
	assign o_speed_ref              = spd_ff;
	assign o_torque_ref             = trq_ff;
	assign o_enc_out_a              = enc_a_ff;
	assign o_enc_out_b              = enc_b_ff;

	// =====================================================================
	// Checks
	// =====================================================================
	sequence servo_off_seen;
		(enable_polarity_setting_ff ? i_servo_on : ~i_servo_on) == 1'b0;
	endsequence

	servo_off_drive_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		servo_off_seen |=> !o_drive_enable && o_speed_ref == 16'h0000 && o_torque_ref == 16'h0000)
		else $error("drive active while servo-on inactive");
	polarity_low_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!i_rst && !enable_polarity_setting_ff && !i_servo_on |=> o_drive_enable)
		else $error("active-low servo-on not honoured");
	polarity_high_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!i_rst && enable_polarity_setting_ff && i_servo_on |=> o_drive_enable)
		else $error("active-high servo-on not honoured");
	pulse_count_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		control_mode_setting_ff == 4'h0 && servo_on_active && pulse_edge && fwd
		|=> o_position_target == $past(o_position_target) + 32'h00000001)
		else $error("pulse did not advance target");
	speed_follow_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		control_mode_setting_ff == 4'h1 && servo_on_active && !reverse_ff |=> o_speed_ref == $past(i_speed_cmd))
		else $error("speed reference wrong");
	torque_follow_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		control_mode_setting_ff == 4'h2 && servo_on_active && !reverse_ff
		|=> o_torque_ref == $past(i_torque_cmd) && o_speed_ref == 16'h0000)
		else $error("torque reference wrong");
	preset_pick_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		control_mode_setting_ff == 4'h3 && servo_on_active && !reverse_ff
		|=> o_speed_ref == $past(preset_ff[preset_idx]))
		else $error("preset speed wrong");
	pair_switch_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		control_mode_setting_ff == 4'h9 |=> o_active_source == ($past(i_mode_switch) ? 3'h2 : 3'h1))
		else $error("paired mode switch wrong");
	internal_pos_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		control_mode_setting_ff == 4'hA && servo_on_active |=> o_position_target == $past(int_target_ff))
		else $error("internal target not applied");
	enc_pass_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		1'b1 |=> o_enc_out_a == $past(i_enc_a) && o_enc_out_b == $past(i_enc_b))
		else $error("encoder output polarity changed");

endmodule

`default_nettype wire

//--- tb/host_motion_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host motion controller: servo-on level and command pulse train.
module host_motion_model
(
	input  wire logic i_sys_clk,
	input  wire logic i_brake_interlock_output,
	output logic      o_servo_on,
	output logic      o_cmd_pulse,
	output logic      o_cmd_sign,
	output logic      o_brake_applied
);
	// The holding brake follows the drive's interlock, never a timer of our own.
	assign o_brake_applied = !i_brake_interlock_output;
	// Start with the line low, which is the active level at the default polarity.
	initial
	begin
		o_servo_on = 1'b0;
		o_cmd_pulse = 1'b0;
		o_cmd_sign = 1'b1;
	end
	// The level changes only just after an edge, so the drive never sees it mid-cycle.
	task automatic set_level(input logic lvl);
		@(posedge i_sys_clk);
		o_servo_on <= lvl;
	endtask
	// Sign is set gap periods ahead of the first pulse; a larger gap models a slow host.
	task automatic pulses(input int n, input logic pos, input int gap);
		@(posedge i_sys_clk);
		o_cmd_sign <= pos;
		repeat (n)
		begin
			repeat (gap) @(posedge i_sys_clk);
			o_cmd_pulse <= 1'b1;
			repeat (gap) @(posedge i_sys_clk);
			o_cmd_pulse <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

//--- tb/tb_servo_mode_and_enable_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "servo_cmd_params.svh"
// ============================================================
// Bench for the servo command front end.
module tb_servo_mode_and_enable_control;
	logic        clk, rst, psel, penable, pwrite, son, pulse, sign, msw, enc_a, enc_b, sel0, sel1, sel2;
	logic        pready, pslverr, drv_en, brake, eo_a, eo_b, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, pos, rd;
	logic [15:0] speed_cmd, torque_cmd, speed_ref, torque_ref;
	logic [2:0]  src;
	int          miscompares, checks_done;
	// Expected source per mode: upper nibble with switch low, lower nibble with switch high.
	// Mode B is an unlisted code and must fall back to pulse position.
	logic [7:0]  tbl [0:11] = '{8'h00, 8'h11, 8'h22, 8'h33, 8'h31, 8'h30, 8'h32, 8'h01, 8'h02, 8'h12, 8'h44, 8'h00};

	servo_mode_and_enable_control uut
	(
		.i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_servo_on(son), .i_cmd_pulse(pulse), .i_cmd_sign(sign), .i_speed_cmd(speed_cmd),
		.i_torque_cmd(torque_cmd), .i_preset_speed_select_0(sel0), .i_preset_speed_select_1(sel1),
		.i_preset_speed_select_2(sel2), .i_mode_switch(msw), .i_enc_a(enc_a), .i_enc_b(enc_b),
		.o_drive_enable(drv_en), .o_brake_interlock_output(brake), .o_active_source(src),
		.o_position_target(pos), .o_speed_ref(speed_ref), .o_torque_ref(torque_ref),
		.o_enc_out_a(eo_a), .o_enc_out_b(eo_b)
	);
	host_motion_model host
	(
		.i_sys_clk(clk), .i_brake_interlock_output(brake), .o_servo_on(son),
		.o_cmd_pulse(pulse), .o_cmd_sign(sign), .o_brake_applied()
	);

	// ============================================================
	// Helpers.
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask
	// One APB transfer; request held until pready is seen high at an edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string what);
		apb(1'b0, a, 32'h0);
		check(rd, e, what);
	endtask
	// Outputs lag inputs by one cycle; four edges leave margin for the pulse edge detector.
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ============================================================
	// Scenarios.
	task automatic t_reset();
		settle();
		rdchk(`OFS_CONTROL_MODE, 32'h0, "mode reset");
		rdchk(`OFS_ENABLE_POLARITY, 32'h0, "polarity reset");
		rdchk(`OFS_DIRECTION, 32'h0, "direction reset");
		check(drv_en, 32'h1, "enable on low level");
		check(brake, 32'h1, "brake released");
		apb(1'b0, 12'h0FC, 32'h0);
		check(err, 32'h1, "unmapped error");
		$display("reset test done");
	endtask
	task automatic t_pulse();
		host.pulses(3, 1'b1, 1);
		settle();
		check(pos, 32'h3, "three forward pulses");
		host.pulses(1, 1'b0, 4);
		settle();
		check(pos, 32'h2, "slow reverse pulse");
		check(src, 32'h0, "pulse source");
		$display("pulse test done");
	endtask
	task automatic t_reverse();
		apb(1'b1, `OFS_DIRECTION, 32'h1);
		host.pulses(2, 1'b1, 1);
		settle();
		check(pos, 32'h0, "reverse counting");
		apb(1'b1, `OFS_CONTROL_MODE, 32'h1);
		@(posedge clk);
		speed_cmd <= 16'h0100;
		enc_a <= 1'b1;
		enc_b <= 1'b0;
		settle();
		check(speed_ref, 32'hFF00, "reversed speed");
		check(eo_a, 32'h1, "encoder a kept");
		check(eo_b, 32'h0, "encoder b kept");
		apb(1'b1, `OFS_DIRECTION, 32'h0);
		settle();
		check(speed_ref, 32'h0100, "analog speed");
		$display("reverse test done");
	endtask
	task automatic t_off();
		host.set_level(1'b1);
		settle();
		check(drv_en, 32'h0, "drive off");
		check(brake, 32'h0, "brake held");
		check(speed_ref, 32'h0, "speed ignored");
		apb(1'b1, `OFS_CONTROL_MODE, 32'h0);
		host.pulses(2, 1'b1, 1);
		settle();
		check(pos, 32'h0, "pulses ignored");
		apb(1'b1, `OFS_ENABLE_POLARITY, 32'h1);
		settle();
		check(drv_en, 32'h1, "active high on");
		$display("servo off test done");
	endtask
	task automatic t_modes();
		for (int m = 0; m < 24; m++)
		begin
			apb(1'b1, `OFS_CONTROL_MODE, 32'(m / 2));
			msw <= m[0];
			settle();
			check(src, m[0] ? tbl[m / 2][2:0] : tbl[m / 2][6:4], "mode source");
		end
		apb(1'b1, `OFS_CONTROL_MODE, 32'h2);
		msw <= 1'b0;
		torque_cmd <= 16'h0321;
		settle();
		check(torque_ref, 32'h0321, "analog torque");
		apb(1'b1, `OFS_PRESET_BASE + 12'h014, 32'h1234);
		apb(1'b1, `OFS_CONTROL_MODE, 32'h3);
		{sel2, sel1, sel0} <= 3'b101;
		settle();
		check(speed_ref, 32'h1234, "preset five");
		apb(1'b1, `OFS_INT_TARGET, 32'h0000ABCD);
		apb(1'b1, `OFS_CONTROL_MODE, 32'hA);
		settle();
		check(pos, 32'h0000ABCD, "internal target");
		$display("mode test done");
	endtask

	// ============================================================
	// Main sequence and hang guard.
	initial
	begin
		{rst, psel, penable, pwrite, paddr, pwdata} = '0;
		{msw, enc_a, enc_b, sel0, sel1, sel2, speed_cmd, torque_cmd} = '0;
		miscompares = 0;
		checks_done = 0;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_pulse();
		t_reverse();
		t_off();
		t_modes();
		report_and_stop();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end
endmodule
`default_nettype wire
